// ### include/tpo_pkg.sv
// Constants shared by the transmit path overhead insertion block
// What this block does
// - Control bit 2 high takes C2 from the serial overhead input port.
// - Control bit 2 low inserts the software C2 value register.
// - Control bit 7 low inserts the software F2 value register.
// - Control bit 7 high takes F2 from the serial overhead input port.
// - F2 value register is 8-bit read/write, resets to zero, feeds software F2.
// - Control byte 0 resets zero; bit 1 reads zero; fields F2, REI, RDI, C2, AIS.
// - MSB driven on next serial fall; device latches it on following rise.
// - Seven further bits follow, one per fall, latched on each next rise.
package tpo_pkg;
  localparam logic [15:0] CTRL0_OFFSET = 16'h1983;
  localparam logic [15:0] C2_VALUE_OFFSET = 16'h199f;
  localparam logic [15:0] F2_VALUE_OFFSET = 16'h19a3;
  localparam logic [15:0] C2_CAPTURE_OFFSET = 16'h19c0;
  localparam logic [15:0] F2_CAPTURE_OFFSET = 16'h19c1;
  localparam int F2_SEL_BIT = 7;
  localparam int REI_MSB = 6;
  localparam int REI_LSB = 5;
  localparam int RDI_MSB = 4;
  localparam int RDI_LSB = 3;
  localparam int C2_SEL_BIT = 2;
  localparam int AIS_BIT = 0;
  localparam logic [7:0] CTRL0_RESET = 8'h00;
  localparam logic [7:0] CTRL0_WRITE_MASK = 8'hfd;
  localparam logic [7:0] C2_VALUE_RESET = 8'h00;
  localparam logic [7:0] F2_VALUE_RESET = 8'h00;
  localparam logic [7:0] READ_IDLE = 8'h00;
  localparam int SLOT_W = 7;
  localparam logic [6:0] POH_SLOTS = 7'h48;
  localparam logic [6:0] C2_WAIT_PERIODS = 7'h10;
  localparam logic [6:0] F2_WAIT_PERIODS = 7'h20;
  localparam logic [6:0] BITS_PER_BYTE = 7'h08;
  localparam logic [6:0] SYNC_LAG_SLOTS = 7'h01;
  localparam int BYTE_COUNT = 2;
  localparam int C2_INDEX = 0;
  localparam int F2_INDEX = 1;
  typedef enum logic [1:0] {
    TPO_PHASE_LOW = 2'b01,
    TPO_PHASE_HIGH = 2'b10
  } tpo_phase_t;
endpackage

// ### verilog/tpo_sync.sv
// Two flip-flop level synchroniser
`timescale 1ns/1ps
`default_nettype none
module tpo_sync (
  input wire logic clk_in,
  input wire logic level_in,
  output logic level_out
);
  logic stage1;

  // First stage feeds only the second stage
  always_ff @(posedge clk_in) begin
    stage1 <= level_in;
    level_out <= stage1;
  end
endmodule
`default_nettype wire

// ### verilog/tpo_capture.sv
// Serial byte capture for one overhead byte slot on the link clock
`timescale 1ns/1ps
`default_nettype none
module tpo_capture #(
  parameter logic [6:0] WAIT_PERIODS = 7'h10
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic sample_in,
  input wire logic [6:0] slot_in,
  input wire logic bit_in,
  output logic [7:0] byte_out,
  output logic done_toggle_out
);
  // Pin synchroniser delays each bit by one serial slot
  localparam logic [6:0] FIRST_SLOT = WAIT_PERIODS + tpo_pkg::SYNC_LAG_SLOTS + 7'h01;
  localparam logic [6:0] LAST_SLOT =
    WAIT_PERIODS + tpo_pkg::SYNC_LAG_SLOTS + tpo_pkg::BITS_PER_BYTE;
  logic [7:0] shift;
  logic in_window;

  assign in_window = (slot_in >= FIRST_SLOT) && (slot_in <= LAST_SLOT);

  // MSB arrives first and is shifted toward the top
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      shift <= 8'h00;
    end else if (sample_in && in_window) begin
      shift <= {shift[6:0], bit_in};
    end
  end

  // Eighth bit completes the byte and flags it to the register domain
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      byte_out <= 8'h00;
      done_toggle_out <= 1'b0;
    end else if (sample_in && slot_in == LAST_SLOT) begin
      byte_out <= {shift[6:0], bit_in};
      done_toggle_out <= ~done_toggle_out;
    end
  end
endmodule
`default_nettype wire

// ### verilog/tpo_top.sv
// Transmit path overhead C2 and F2 insertion with serial overhead port
`timescale 1ns/1ps
`default_nettype none
module tpo_top (
  input wire logic clk_in,
  input wire logic srst_in,
  input wire logic link_clk_in,
  input wire logic [15:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [7:0] rdata_out,
  input wire logic serial_overhead_in,
  output logic overhead_serial_clock_out,
  output logic overhead_window_enable_out,
  output logic overhead_frame_mark_out,
  output logic [7:0] c2_byte_out,
  output logic [7:0] f2_byte_out,
  output logic [1:0] rei_type_out,
  output logic [1:0] rdi_type_out,
  output logic ais_enable_out
);

  // Register domain state
  logic [7:0] path_overhead_control_0;
  logic [7:0] path_signal_label_value;
  logic [7:0] path_user_channel_value;
  logic [7:0] c2_port_byte;
  logic [7:0] f2_port_byte;
  logic [7:0] next_rdata;

  // Link domain state
  logic link_rst;
  tpo_pkg::tpo_phase_t phase;
  logic [6:0] slot;
  logic data_sync;
  logic sample;
  logic [7:0] link_byte [tpo_pkg::BYTE_COUNT];
  logic link_toggle [tpo_pkg::BYTE_COUNT];

  // Register domain view of capture events
  logic sys_toggle [tpo_pkg::BYTE_COUNT];
  logic sys_toggle_d [tpo_pkg::BYTE_COUNT];
  logic byte_event [tpo_pkg::BYTE_COUNT];

  // ---------------------------------------------------------------
  // Register file
  // ---------------------------------------------------------------

  // Control byte 0; bit 1 is read-only and always zero
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      path_overhead_control_0 <= tpo_pkg::CTRL0_RESET;
    end else if (wr_in && addr_in == tpo_pkg::CTRL0_OFFSET) begin
      path_overhead_control_0 <= wdata_in & tpo_pkg::CTRL0_WRITE_MASK;
    end
  end

  // Software C2 value
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      path_signal_label_value <= tpo_pkg::C2_VALUE_RESET;
    end else if (wr_in && addr_in == tpo_pkg::C2_VALUE_OFFSET) begin
      path_signal_label_value <= wdata_in;
    end
  end

  // Software F2 value
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      path_user_channel_value <= tpo_pkg::F2_VALUE_RESET;
    end else if (wr_in && addr_in == tpo_pkg::F2_VALUE_OFFSET) begin
      path_user_channel_value <= wdata_in;
    end
  end

  // Read decode; unmapped addresses read zero
  always_comb begin
    next_rdata = tpo_pkg::READ_IDLE;
    if (rd_in) begin
      unique case (addr_in)
        tpo_pkg::CTRL0_OFFSET: begin
          next_rdata = path_overhead_control_0;
        end
        tpo_pkg::C2_VALUE_OFFSET: begin
          next_rdata = path_signal_label_value;
        end
        tpo_pkg::F2_VALUE_OFFSET: begin
          next_rdata = path_user_channel_value;
        end
        tpo_pkg::C2_CAPTURE_OFFSET: begin
          next_rdata = c2_port_byte;
        end
        tpo_pkg::F2_CAPTURE_OFFSET: begin
          next_rdata = f2_port_byte;
        end
        default: begin
          next_rdata = tpo_pkg::READ_IDLE;
        end
      endcase
    end
  end

  // Read data stands in the cycle after the strobe only
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      rdata_out <= tpo_pkg::READ_IDLE;
    end else begin
      rdata_out <= next_rdata;
    end
  end

  // Control fields that steer the rest of the transmit path
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      rei_type_out <= 2'h0;
      rdi_type_out <= 2'h0;
      ais_enable_out <= 1'b0;
    end else begin
      rei_type_out <= path_overhead_control_0[tpo_pkg::REI_MSB:tpo_pkg::REI_LSB];
      rdi_type_out <= path_overhead_control_0[tpo_pkg::RDI_MSB:tpo_pkg::RDI_LSB];
      ais_enable_out <= path_overhead_control_0[tpo_pkg::AIS_BIT];
    end
  end

  // ---------------------------------------------------------------
  // Link domain: serial clock, frame mark and slot count
  // ---------------------------------------------------------------

  // Reset carried into the link domain
  tpo_sync u_rst_sync (
    .clk_in(link_clk_in),
    .level_in(srst_in),
    .level_out(link_rst)
  );

  // Serial data pin resolved before any logic reads it
  tpo_sync u_data_sync (
    .clk_in(link_clk_in),
    .level_in(serial_overhead_in),
    .level_out(data_sync)
  );

  // Serial clock is the link clock divided by two
  always_ff @(posedge link_clk_in) begin
    if (link_rst) begin
      phase <= tpo_pkg::TPO_PHASE_LOW;
      overhead_serial_clock_out <= 1'b0;
    end else begin
      unique case (phase)
        tpo_pkg::TPO_PHASE_LOW: begin
          phase <= tpo_pkg::TPO_PHASE_HIGH;
          overhead_serial_clock_out <= 1'b1;
        end
        tpo_pkg::TPO_PHASE_HIGH: begin
          phase <= tpo_pkg::TPO_PHASE_LOW;
          overhead_serial_clock_out <= 1'b0;
        end
        default: begin
          phase <= tpo_pkg::TPO_PHASE_LOW;
          overhead_serial_clock_out <= 1'b0;
        end
      endcase
    end
  end

  // Bit slot advances on every serial falling edge
  always_ff @(posedge link_clk_in) begin
    if (link_rst) begin
      slot <= tpo_pkg::POH_SLOTS - 7'h01;
    end else if (phase == tpo_pkg::TPO_PHASE_HIGH) begin
      if (slot == tpo_pkg::POH_SLOTS - 7'h01) begin
        slot <= 7'h00;
      end else begin
        slot <= slot + 7'h01;
      end
    end
  end

  // Enable and frame mark high for the single serial period of slot 0
  always_ff @(posedge link_clk_in) begin
    if (link_rst) begin
      overhead_window_enable_out <= 1'b0;
      overhead_frame_mark_out <= 1'b0;
    end else if (phase == tpo_pkg::TPO_PHASE_HIGH) begin
      overhead_window_enable_out <= (slot == tpo_pkg::POH_SLOTS - 7'h01);
      overhead_frame_mark_out <= (slot == tpo_pkg::POH_SLOTS - 7'h01);
    end
  end

  // Take the bit during the high half of the serial clock
  assign sample = (phase == tpo_pkg::TPO_PHASE_HIGH);

  // One capture per port-sourced byte: C2 after 16 periods, F2 after 32
  genvar gi;
  generate
    for (gi = 0; gi < tpo_pkg::BYTE_COUNT; gi++) begin : g_capture
      tpo_capture #(
        .WAIT_PERIODS((gi == tpo_pkg::C2_INDEX) ? tpo_pkg::C2_WAIT_PERIODS :
                                                  tpo_pkg::F2_WAIT_PERIODS)
      ) u_capture (
        .clk_in(link_clk_in),
        .rst_in(link_rst),
        .sample_in(sample),
        .slot_in(slot),
        .bit_in(data_sync),
        .byte_out(link_byte[gi]),
        .done_toggle_out(link_toggle[gi])
      );

      // Completion toggle crosses into the register domain
      tpo_sync u_toggle_sync (
        .clk_in(clk_in),
        .level_in(link_toggle[gi]),
        .level_out(sys_toggle[gi])
      );

      always_ff @(posedge clk_in) begin
        if (srst_in) begin
          sys_toggle_d[gi] <= 1'b0;
        end else begin
          sys_toggle_d[gi] <= sys_toggle[gi];
        end
      end

      assign byte_event[gi] = sys_toggle[gi] ^ sys_toggle_d[gi];
    end
  endgenerate

  // ---------------------------------------------------------------
  // Register domain: captured bytes and inserted values
  // ---------------------------------------------------------------

  // Held link byte is stable for a whole frame once its toggle is seen
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      c2_port_byte <= 8'h00;
    end else if (byte_event[tpo_pkg::C2_INDEX]) begin
      c2_port_byte <= link_byte[tpo_pkg::C2_INDEX];
    end
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      f2_port_byte <= 8'h00;
    end else if (byte_event[tpo_pkg::F2_INDEX]) begin
      f2_port_byte <= link_byte[tpo_pkg::F2_INDEX];
    end
  end

  // C2 source select
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      c2_byte_out <= tpo_pkg::C2_VALUE_RESET;
    end else if (path_overhead_control_0[tpo_pkg::C2_SEL_BIT]) begin
      c2_byte_out <= c2_port_byte;
    end else begin
      c2_byte_out <= path_signal_label_value;
    end
  end

  // F2 source select
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      f2_byte_out <= tpo_pkg::F2_VALUE_RESET;
    end else if (path_overhead_control_0[tpo_pkg::F2_SEL_BIT]) begin
      f2_byte_out <= f2_port_byte;
    end else begin
      f2_byte_out <= path_user_channel_value;
    end
  end

endmodule
`default_nettype wire

// ### verif/tpo_properties.sv
// Port assertions for the overhead insertion block
`timescale 1ns/1ps
`default_nettype none
module tpo_properties (
  input wire logic clk_in,
  input wire logic srst_in,
  input wire logic link_clk_in,
  input wire logic [15:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  input wire logic [7:0] rdata_out,
  input wire logic overhead_serial_clock_out,
  input wire logic overhead_window_enable_out,
  input wire logic overhead_frame_mark_out,
  input wire logic [7:0] c2_byte_out,
  input wire logic [7:0] f2_byte_out,
  input wire logic [1:0] rei_type_out,
  input wire logic [1:0] rdi_type_out,
  input wire logic ais_enable_out
);
  logic [7:0] ctrl;
  logic [7:0] c2_sw;
  logic [7:0] f2_sw;
  logic en;
  logic sclk;
  assign en = overhead_window_enable_out;
  assign sclk = overhead_serial_clock_out;
  logic [2:0] link_age;
  // Link outputs settle only once reset has crossed into the link domain
  always_ff @(posedge link_clk_in) begin
    if (srst_in) begin
      link_age <= 3'h0;
    end else if (link_age != 3'h7) begin
      link_age <= link_age + 3'h1;
    end
  end
  // Shadow of the software registers
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      ctrl <= 8'h00;
      c2_sw <= 8'h00;
      f2_sw <= 8'h00;
    end else if (wr_in) begin
      if (addr_in == tpo_pkg::CTRL0_OFFSET) ctrl <= wdata_in & 8'hfd;
      if (addr_in == tpo_pkg::C2_VALUE_OFFSET) c2_sw <= wdata_in;
      if (addr_in == tpo_pkg::F2_VALUE_OFFSET) f2_sw <= wdata_in;
    end
  end
  property p_rd_idle;
    @(posedge clk_in) disable iff (srst_in) !$past(rd_in) |-> rdata_out == 8'h00;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
  property p_ctrl_rb;
    @(posedge clk_in) disable iff (srst_in)
      $past(rd_in) && $past(addr_in) == tpo_pkg::CTRL0_OFFSET |-> rdata_out == $past(ctrl);
  endproperty
  a_ctrl_rb: assert property (p_ctrl_rb) else $error("control readback wrong");
  property p_f2_rb;
    @(posedge clk_in) disable iff (srst_in)
      $past(rd_in) && $past(addr_in) == tpo_pkg::F2_VALUE_OFFSET |-> rdata_out == $past(f2_sw);
  endproperty
  a_f2_rb: assert property (p_f2_rb) else $error("F2 value readback wrong");
  property p_c2_sw;
    @(posedge clk_in) disable iff (srst_in) !$past(ctrl[2]) |-> c2_byte_out == $past(c2_sw);
  endproperty
  a_c2_sw: assert property (p_c2_sw) else $error("C2 software byte wrong");
  property p_f2_sw;
    @(posedge clk_in) disable iff (srst_in) !$past(ctrl[7]) |-> f2_byte_out == $past(f2_sw);
  endproperty
  a_f2_sw: assert property (p_f2_sw) else $error("F2 software byte wrong");
  property p_fields;
    @(posedge clk_in) disable iff (srst_in)
      {rei_type_out, rdi_type_out, ais_enable_out} == {$past(ctrl[6:3]), $past(ctrl[0])};
  endproperty
  a_fields: assert property (p_fields) else $error("control fields wrong");
  property p_mark_eq;
    @(posedge link_clk_in) disable iff (srst_in || link_age < 3'h4) en == overhead_frame_mark_out;
  endproperty
  a_mark_eq: assert property (p_mark_eq) else $error("enable and mark differ");
  property p_en_width;
    @(posedge link_clk_in) disable iff (srst_in || link_age < 3'h4) $rose(en) |-> ##1 en ##1 !en;
  endproperty
  a_en_width: assert property (p_en_width) else $error("enable width wrong");
  property p_frame;
    @(posedge link_clk_in) disable iff (srst_in || link_age < 3'h4) $rose(en) |-> ##144 $rose(en);
  endproperty
  a_frame: assert property (p_frame) else $error("frame spacing wrong");
  property p_sclk;
    @(posedge link_clk_in) disable iff (srst_in || link_age < 3'h4) sclk |=> !sclk;
  endproperty
  a_sclk: assert property (p_sclk) else $error("serial clock high too long");
endmodule
`default_nettype wire

// ### verif/tpo_far_end.sv
// Model of the external overhead insertion circuit
`timescale 1ns/1ps
`default_nettype none
module tpo_far_end (
  input wire logic sclk_in,
  input wire logic enable_in,
  input wire logic mark_in,
  input wire logic [7:0] c2_in,
  input wire logic [7:0] f2_in,
  output logic data_out
);
  logic [7:0] periods = 8'hc8;
  logic [7:0] c2_hold = 8'h00;
  logic [7:0] f2_hold = 8'h00;
  initial data_out = 1'b0;
  // Watch enable and mark on every rise and restart the count each frame
  always @(posedge sclk_in) begin
    if (enable_in && mark_in) begin
      periods <= 8'h00;
      c2_hold <= c2_in;
      f2_hold <= f2_in;
    end else if (periods != 8'hc8) begin
      periods <= periods + 8'h01;
    end
  end
  // Bits go out MSB first on the fall before the taking rise; no insert strobe
  always @(negedge sclk_in) begin
    if (periods >= 8'h10 && periods <= 8'h17) data_out <= c2_hold[3'(8'h17 - periods)];
    else if (periods >= 8'h20 && periods <= 8'h27) data_out <= f2_hold[3'(8'h27 - periods)];
    else data_out <= ~data_out;
  end
endmodule
`default_nettype wire

// ### verif/test_tpo_top.sv
// Self-checking bench for the overhead insertion block
`timescale 1ns/1ps
`default_nettype none
module test_tpo_top;
  logic clk_in = 1'b0;
  logic link_clk_in = 1'b0;
  logic srst_in = 1'b1;
  logic [15:0] addr_in = 16'h0000;
  logic [7:0] wdata_in = 8'h00;
  logic wr_in = 1'b0;
  logic rd_in = 1'b0;
  logic ser;
  logic sclk, en, mark, ais;
  logic [7:0] rdata_out, c2_byte_out, f2_byte_out, c2p, f2p, c2s, f2s, c, d;
  logic [1:0] rei, rdi;
  logic [31:0] seed = 32'h3d54;
  logic [7:0] sel [3] = '{8'h04, 8'h80, 8'h84};
  int n_errors = 0;
  int tests_run = 0;
  tpo_top dut (.clk_in, .srst_in, .link_clk_in, .addr_in, .wdata_in, .wr_in, .rd_in,
    .rdata_out, .serial_overhead_in(ser), .overhead_serial_clock_out(sclk),
    .overhead_window_enable_out(en), .overhead_frame_mark_out(mark), .c2_byte_out,
    .f2_byte_out, .rei_type_out(rei), .rdi_type_out(rdi), .ais_enable_out(ais));
  tpo_far_end far (.sclk_in(sclk), .enable_in(en), .mark_in(mark), .c2_in(c2p),
    .f2_in(f2p), .data_out(ser));
  initial forever #2.5 clk_in = ~clk_in;
  initial begin
    #7;
    forever #32 link_clk_in = ~link_clk_in;
  end
  function automatic logic [7:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[7:0];
  endfunction
  function automatic logic [7:0] pick(input logic s, input logic [7:0] p, input logic [7:0] w);
    return s ? p : w;
  endfunction
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] v);
    @(posedge clk_in);
    addr_in <= a;
    wdata_in <= v;
    wr_in <= 1'b1;
    @(posedge clk_in);
    wr_in <= 1'b0;
  endtask
  task automatic rdchk(input logic [15:0] a, input logic [7:0] exp, input string what);
    @(posedge clk_in);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge clk_in);
    rd_in <= 1'b0;
    #1 chk(what, exp, rdata_out);
  endtask
  task automatic final_report();
    $display("Checks %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic frames(input int n);
    int seen;
    int t;
    logic last;
    seen = 0;
    t = 0;
    last = mark;
    while (seen < n && t < 2500 * n) begin
      @(posedge clk_in);
      if (mark && !last) seen++;
      last = mark;
      t++;
    end
    if (seen < n) begin
      n_errors++;
      $display("CHECK FAILED frame mark expected %0d seen %0d", n, seen);
      final_report();
    end
  endtask
  initial begin
    c2p = 8'h00;
    f2p = 8'h00;
    repeat (20) @(posedge clk_in);
    srst_in <= 1'b0;
    rdchk(tpo_pkg::CTRL0_OFFSET, 8'h00, "ctrl reset");
    rdchk(tpo_pkg::F2_VALUE_OFFSET, 8'h00, "f2 reset");
    rdchk(tpo_pkg::C2_VALUE_OFFSET, 8'h00, "c2 reset");
    wr(16'h1984, 8'h5a);
    rdchk(16'h1984, 8'h00, "unmapped");
    wr(tpo_pkg::CTRL0_OFFSET, 8'hff);
    rdchk(tpo_pkg::CTRL0_OFFSET, 8'hfd, "ctrl bit1 ro");
    chk("fields", 8'h1f, {3'b000, rei, rdi, ais});
    $display("Test registers done");
    for (int i = 0; i < 4; i++) begin
      c = rnd() & 8'h7b;
      c2s = rnd();
      f2s = rnd();
      wr(tpo_pkg::CTRL0_OFFSET, c);
      wr(tpo_pkg::C2_VALUE_OFFSET, c2s);
      wr(tpo_pkg::F2_VALUE_OFFSET, f2s);
      rdchk(tpo_pkg::F2_VALUE_OFFSET, f2s, "f2 value");
      chk("c2 sw byte", c2s, c2_byte_out);
      chk("f2 sw byte", f2s, f2_byte_out);
      chk("fields", {3'b000, c[6:3], c[0]}, {3'b000, rei, rdi, ais});
    end
    $display("Test software source done");
    for (int i = 0; i < 3; i++) begin
      c2p <= rnd();
      f2p <= rnd();
      d = rnd() & 8'h79;
      wr(tpo_pkg::CTRL0_OFFSET, d | sel[i]);
      frames(3);
      chk("c2 out", pick(sel[i][2], c2p, c2s), c2_byte_out);
      chk("f2 out", pick(sel[i][7], f2p, f2s), f2_byte_out);
      rdchk(tpo_pkg::C2_CAPTURE_OFFSET, c2p, "c2 captured");
      rdchk(tpo_pkg::F2_CAPTURE_OFFSET, f2p, "f2 captured");
    end
    $display("Test serial source done");
    final_report();
  end
endmodule
bind tpo_top tpo_properties u_props (.clk_in, .srst_in, .link_clk_in, .addr_in, .wdata_in,
  .wr_in, .rd_in, .rdata_out, .overhead_serial_clock_out, .overhead_window_enable_out,
  .overhead_frame_mark_out, .c2_byte_out, .f2_byte_out, .rei_type_out, .rdi_type_out,
  .ais_enable_out);
`default_nettype wire
